/* rcw_params.svh */
// constants for the runaway code watchdog: offsets, fields, resets, counts
`ifndef RCW_PARAMS_SVH
`define RCW_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------
`define RCW_IDX_OPTION      16'h001f
`define RCW_IDX_CLEAR       16'hffff
`define RCW_IDX_CAUSE       16'h0020
`define RCW_IDX_STATUS      16'h0021
`define RCW_ADDR_W          18

// ----------------------------------------------------------------------
// system option register fields and reset values
// ----------------------------------------------------------------------
`define RCW_OPT_DISABLE     0
`define RCW_OPT_STOP_EN     1
`define RCW_OPT_RATE        2
`define RCW_OPT_RESET       8'h00
`define RCW_OPT_POR_ONLY    8'hf0

// ----------------------------------------------------------------------
// reset cause fields
// ----------------------------------------------------------------------
`define RCW_CAUSE_WDOG      0
`define RCW_CAUSE_ILLOP     1

// ----------------------------------------------------------------------
// counter widths and timing counts in doubled clock cycles
// ----------------------------------------------------------------------
`define RCW_PRE_W           12
`define RCW_CNT_W           6
`define RCW_SHORT_BITS      13
`define RCW_CLR_LO          4
`define RCW_CLR_HI          11
`define RCW_RST_PULSE       32
`define RCW_POR_CLEAR       4096

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define RCW_RESP_OKAY       2'h0
`define RCW_RESP_SLVERR     2'h2

`endif

/* rcw_pkg.sv */
// types shared by the runaway code watchdog modules
package rcw_pkg;

  // ----------------------------------------------------------------------
  // watchdog phases
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_HOLD,
    PH_COUNT,
    PH_FIRE
  } rcw_phase_t;

  // ----------------------------------------------------------------------
  // synchroniser state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] first;
    logic [1:0] second;
  } rcw_sync_t;

  // ----------------------------------------------------------------------
  // watchdog state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        awReady;
    logic        awHeld;
    logic [17:0] awAddr;
    logic        wReady;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [7:0]  option;
    logic [1:0]  cause;
    logic [11:0] pre;
    logic [5:0]  cnt;
    rcw_phase_t  phase;
    logic [5:0]  pulseCnt;
    logic [12:0] porCnt;
    logic        porDone;
    logic        monTst;
    logic        monBlank;
    logic        sysRst;
    logic        illegalRst;
    logic        pinOe;
  } rcw_state_t;

endpackage : rcw_pkg

/* rcw_runaway_watchdog.sv */
// runaway code watchdog with its axi4-lite register slave
//
// Contract
// - watchdog is a 6-bit counter behind a 12-bit prescaler on doubled clock
// - rate bit 1 times out at 2^13-2^4, 0 at 2^18-2^4; resets clear it
// - an overflow that was not cleared in time raises a system reset
// - any write to the clear location zeroes counter and prescaler stages 12..5
// - reading the clear location returns reset vector low byte, no side effect
// - timeout drives reset pin low 32 cycles and sets watchdog cause flag
// - the stop instruction clears the prescaler
// - power-on logic clears the prescaler 4096 cycles after power-up
// - any internal reset clears prescaler and counter
// - a reset vector fetch clears the prescaler
// - disable bit 1 stops counting and resetting; 0 runs normally
// - the watchdog never raises an interrupt, only a reset
// - monitor entry with test voltage on irq disables while voltage stays
// - monitor entry by blank vectors disables until next power-on reset
// - counting continues in wait mode; software clears it from interrupts
// - stop mode removes the clock and clears the prescaler
// - stop disallowed by option turns a stop instruction into illegal opcode reset
// - during break, test voltage on reset pin disables the watchdog
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

`include "rcw_params.svh"

module rcw_runaway_watchdog
  import rcw_pkg::*;
#(
  parameter logic [7:0] RESET_VECTOR_LOW = 8'h00  // value is arbitrary
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core events on the same clock
  input  wire logic        internalReset,
  input  wire logic        vectorFetch,
  input  wire logic        stopExec,
  input  wire logic        stopMode,
  input  wire logic        monitorEnter,
  input  wire logic        blankVectors,
  input  wire logic        breakState,
  // test voltage detectors, asynchronous
  input  wire logic        irqHighVoltage,
  input  wire logic        rstHighVoltage,
  // outputs
  output logic             systemReset,
  output logic             illegalOpReset,
  output logic             rstPinOut,
  output logic             rstPinOe
);

  // ----------------------------------------------------------------------
  // byte addresses and widths
  // ----------------------------------------------------------------------
  localparam logic [17:0] ADDR_OPTION = {`RCW_IDX_OPTION, 2'b00};
  localparam logic [17:0] ADDR_CLEAR  = {`RCW_IDX_CLEAR, 2'b00};
  localparam logic [17:0] ADDR_CAUSE  = {`RCW_IDX_CAUSE, 2'b00};
  localparam logic [17:0] ADDR_STATUS = {`RCW_IDX_STATUS, 2'b00};
  localparam int          CHAIN_W     = `RCW_PRE_W + `RCW_CNT_W;
  localparam logic [5:0]  PULSE_LAST  = 6'(`RCW_RST_PULSE - 1);
  localparam logic [12:0] POR_LAST    = 13'(`RCW_POR_CLEAR - 1);

  rcw_state_t           s;
  rcw_state_t           n;
  logic [1:0]           hv;
  logic                 irqHv;
  logic                 rstHv;
  logic                 disabled;
  logic                 stopOk;
  logic [CHAIN_W-1:0]   chain;
  logic                 expire;
  logic [31:0]          rdMux;
  logic                 rdHit;

  // ----------------------------------------------------------------------
  // test voltage levels cross in through two flops
  // ----------------------------------------------------------------------
  rcw_sync u_sync (
    .clk   (clk),
    .rst   (rst),
    .async ({rstHighVoltage, irqHighVoltage}),
    .sync  (hv)
  );

  assign irqHv = hv[0];
  assign rstHv = hv[1];

  // ----------------------------------------------------------------------
  // disable conditions
  // ----------------------------------------------------------------------
  // option bit, monitor entry modes and break with test voltage
  always_comb begin
    disabled = s.option[`RCW_OPT_DISABLE]
             | s.monBlank
             | (s.monTst & (irqHv | rstHv))
             | (breakState & rstHv);
  end

  // stop only runs when the option allows it
  assign stopOk = s.option[`RCW_OPT_STOP_EN];

  // ----------------------------------------------------------------------
  // overflow detection on the counter chain
  // ----------------------------------------------------------------------
  // the chain counts through wait mode; only stop mode freezes it
  always_comb begin
    chain  = {s.cnt, s.pre};
    expire = 1'b0;
    if (s.phase == PH_COUNT && !stopMode) begin
      if (s.option[`RCW_OPT_RATE]) begin
        expire = &chain[`RCW_SHORT_BITS-1:0];
      end else begin
        expire = &chain;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------
  // the clear location answers with the vector byte and touches nothing
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_OPTION: rdMux = {24'h00_0000, s.option};
      ADDR_CLEAR:  rdMux = {24'h00_0000, RESET_VECTOR_LOW};
      ADDR_CAUSE:  rdMux = {30'h0000_0000, s.cause};
      ADDR_STATUS: rdMux = {12'h000, (s.phase == PH_FIRE), disabled,
                            s.cnt, s.pre};
      default:     rdHit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    n            = s;
    n.sysRst     = 1'b0;
    n.illegalRst = 1'b0;

    // write address and data are taken in either order
    if (s.awReady && s_axi_awvalid) begin
      n.awHeld  = 1'b1;
      n.awAddr  = s_axi_awaddr;
      n.awReady = 1'b0;
    end
    if (s.wReady && s_axi_wvalid) begin
      n.wHeld  = 1'b1;
      n.wData  = s_axi_wdata;
      n.wStrb  = s_axi_wstrb;
      n.wReady = 1'b0;
    end

    // response closes the write and reopens both channels
    if (s.bValid && s_axi_bready) begin
      n.bValid  = 1'b0;
      n.awReady = 1'b1;
      n.wReady  = 1'b1;
    end

    // read answers one cycle after the address is taken
    if (s.arReady && s_axi_arvalid) begin
      n.arReady = 1'b0;
      n.rValid  = 1'b1;
      n.rData   = rdMux;
      n.rResp   = rdHit ? `RCW_RESP_OKAY : `RCW_RESP_SLVERR;
    end
    if (s.rValid && s_axi_rready) begin
      n.rValid  = 1'b0;
      n.arReady = 1'b1;
    end

    // the counter chain advances every enabled cycle
    if (s.phase == PH_COUNT && !stopMode) begin
      {n.cnt, n.pre} = CHAIN_W'(chain + 1'b1);
    end

    // power-on prescaler clear happens once
    if (!s.porDone) begin
      if (s.porCnt == POR_LAST) begin
        n.porDone = 1'b1;
        n.pre     = '0;
      end else begin
        n.porCnt = s.porCnt + 13'h0001;
      end
    end

    // stop clears the prescaler and holds it while stopped
    if ((stopExec && stopOk) || stopMode) begin
      n.pre = '0;
    end

    // a stop that the option forbids becomes an illegal opcode reset
    if (stopExec && !stopOk) begin
      n.illegalRst             = 1'b1;
      n.cause[`RCW_CAUSE_ILLOP] = 1'b1;
    end

    // a reset vector fetch clears the prescaler
    if (vectorFetch) begin
      n.pre = '0;
    end

    // register write once both halves are held
    if (s.awHeld && s.wHeld && !s.bValid) begin
      n.awHeld = 1'b0;
      n.wHeld  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = `RCW_RESP_OKAY;
      unique case (s.awAddr)
        ADDR_OPTION: begin
          if (s.wStrb[0]) begin
            n.option = s.wData[7:0];
          end
        end
        ADDR_CLEAR: begin
          // any value and any strobe restarts the period
          n.cnt                          = '0;
          n.pre[`RCW_CLR_HI:`RCW_CLR_LO] = '0;
        end
        ADDR_CAUSE: begin
          // write one to clear, a new event below still wins
          if (s.wStrb[0]) begin
            n.cause = s.cause & ~s.wData[1:0];
          end
        end
        ADDR_STATUS: begin
          n.bResp = `RCW_RESP_OKAY;
        end
        default: n.bResp = `RCW_RESP_SLVERR;
      endcase
      // a forbidden stop in the same cycle keeps its flag
      if (stopExec && !stopOk) begin
        n.cause[`RCW_CAUSE_ILLOP] = 1'b1;
      end
    end

    // monitor entry mode is caught on the entry strobe
    if (monitorEnter) begin
      if (irqHv) begin
        n.monTst = 1'b1;
      end else if (blankVectors) begin
        n.monBlank = 1'b1;
      end
    end else if (s.monTst && !(irqHv || rstHv)) begin
      n.monTst = 1'b0;
    end

    // internal reset clears both stages and the low option bits
    if (internalReset) begin
      n.pre    = '0;
      n.cnt    = '0;
      n.option = s.option & `RCW_OPT_POR_ONLY;
    end

    // phase sequencing: hold, count, fire the reset pulse
    unique case (s.phase)
      PH_HOLD: begin
        n.pre = '0;
        n.cnt = '0;
        if (!disabled) begin
          n.phase = PH_COUNT;
        end
      end
      PH_COUNT: begin
        if (disabled) begin
          n.phase = PH_HOLD;
          n.pre   = '0;
          n.cnt   = '0;
        end else if (expire && !internalReset) begin
          // only a reset leaves the block, never an interrupt
          n.phase                  = PH_FIRE;
          n.sysRst                 = 1'b1;
          n.pinOe                  = 1'b1;
          n.pulseCnt               = '0;
          n.cause[`RCW_CAUSE_WDOG] = 1'b1;
          n.pre                    = '0;
          n.cnt                    = '0;
          n.option = s.option & `RCW_OPT_POR_ONLY;
        end
      end
      PH_FIRE: begin
        n.pre = '0;
        n.cnt = '0;
        if (s.pulseCnt == PULSE_LAST) begin
          n.pinOe = 1'b0;
          n.phase = PH_HOLD;
        end else begin
          n.pulseCnt = s.pulseCnt + 6'h01;
        end
      end
      // the spare phase code falls back to hold
      default: n.phase = PH_HOLD;
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // power-on reset clears everything but the ready flags, which it sets, the blank vector latch included
  always_ff @(posedge clk) begin
    if (rst) begin
      s         <= '0;
      s.awReady <= 1'b1;
      s.wReady  <= 1'b1;
      s.arReady <= 1'b1;
      s.option  <= `RCW_OPT_RESET;
      s.phase   <= PH_HOLD;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------------
  // outputs straight from the state register, reset pin level tied low
  // ----------------------------------------------------------------------
  assign s_axi_awready  = s.awReady;
  assign s_axi_wready   = s.wReady;
  assign s_axi_bvalid   = s.bValid;
  assign s_axi_bresp    = s.bResp;
  assign s_axi_arready  = s.arReady;
  assign s_axi_rvalid   = s.rValid;
  assign s_axi_rdata    = s.rData;
  assign s_axi_rresp    = s.rResp;
  assign systemReset    = s.sysRst;
  assign illegalOpReset = s.illegalRst;
  assign rstPinOut      = 1'b0;       // open drain, only ever pulls low
  assign rstPinOe       = s.pinOe;

endmodule // rcw_runaway_watchdog

`default_nettype wire

/* rcw_runaway_watchdog_checker.sv */
// port-level assertion checker for the runaway code watchdog
`timescale 1ns/100ps
`default_nettype none

module rcw_runaway_watchdog_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic stopMode,
  input wire logic stopExec,
  input wire logic breakState,
  input wire logic rstHighVoltage,
  input wire logic systemReset,
  input wire logic illegalOpReset,
  input wire logic rstPinOut,
  input wire logic rstPinOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // timeout reset and reset pin
  // ----------------------------------------------------------------------
  a_pin_pulse_len: assert property ($rose(rstPinOe) |-> rstPinOe[*8] ##24 rstPinOe ##1 !rstPinOe)
    else $error("reset pin pulse length wrong");
  a_pin_drive_low: assert property (rstPinOe |-> !rstPinOut)
    else $error("reset pin driven high");
  a_timeout_pin: assert property (systemReset |-> ##[0:1] rstPinOe)
    else $error("timeout without reset pin pulse");
  a_timeout_single: assert property (systemReset |=> !systemReset)
    else $error("timeout reset longer than one cycle");

  // ----------------------------------------------------------------------
  // stop, break and bus
  // ----------------------------------------------------------------------
  a_illop_cause: assert property (illegalOpReset |-> $past(stopExec))
    else $error("illegal opcode reset without stop");
  a_illop_single: assert property (illegalOpReset |=> !illegalOpReset)
    else $error("illegal opcode reset too long");
  a_stop_frozen: assert property (stopMode |=> !systemReset)
    else $error("timeout while stopped");
  a_break_quiet: assert property ((breakState && rstHighVoltage)[*5] |-> !systemReset)
    else $error("timeout during break with test voltage");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : rcw_runaway_watchdog_checker

bind rcw_runaway_watchdog rcw_runaway_watchdog_checker u_rcw_runaway_watchdog_checker (
  .clk(clk), .rst(rst), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .stopMode(stopMode), .stopExec(stopExec),
  .breakState(breakState), .rstHighVoltage(rstHighVoltage), .systemReset(systemReset),
  .illegalOpReset(illegalOpReset), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe));

`default_nettype wire

/* rcw_sync.sv */
// two-stage synchroniser for the test voltage detector levels
`timescale 1ns/100ps
`default_nettype none

module rcw_sync
  import rcw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] async,
  output logic      [1:0] sync
);

  rcw_sync_t s;
  rcw_sync_t n;

  // ----------------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------------
  always_comb begin
    n        = s;
    n.first  = async;
    n.second = s.first;
  end

  // register both stages
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sync = s.second;

endmodule // rcw_sync

`default_nettype wire

/* testbench.sv */
// self-checking testbench for the runaway code watchdog
`timescale 1ns/100ps
`default_nettype none
`include "rcw_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
  localparam logic [17:0] A_OPT = {`RCW_IDX_OPTION, 2'b00};
  localparam logic [17:0] A_CLR = {`RCW_IDX_CLEAR, 2'b00};
  localparam logic [17:0] A_CAU = {`RCW_IDX_CAUSE, 2'b00};
  localparam logic [17:0] A_STA = {`RCW_IDX_STATUS, 2'b00};
  logic        clk, rst, awValid, wValid, bReady, arValid, rReady, intRst, vecFetch;
  logic        stopExec, stopMode, monEnter, blankVec, brk, irqHv, rstHv;
  logic        awReady, wReady, bValid, arReady, rValid, sysRst, illOp, pinOut, pinOe;
  logic [17:0] awAddr, arAddr, a;
  logic [31:0] wData, rData, d;
  logic [3:0]  wStrb;
  logic [1:0]  bResp, rResp;
  int          num_errors, checked, resets, seed, i, r0;

  rcw_runaway_watchdog #(.RESET_VECTOR_LOW(8'ha5)) u_rcw_runaway_watchdog (
    .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .internalReset(intRst), .vectorFetch(vecFetch), .stopExec(stopExec), .stopMode(stopMode),
    .monitorEnter(monEnter), .blankVectors(blankVec), .breakState(brk),
    .irqHighVoltage(irqHv), .rstHighVoltage(rstHv), .systemReset(sysRst),
    .illegalOpReset(illOp), .rstPinOut(pinOut), .rstPinOe(pinOe));

  // ----------------------------------------------------------------------
  // clock, reset counter and closing report
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (sysRst === 1'b1) resets <= resets + 1;

  task automatic tally_and_finish();
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // bus master tasks, bready and rready stay high
  // ----------------------------------------------------------------------
  task automatic wr(input logic [17:0] ad, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] e);
    int k;
    awAddr <= ad; wData <= v; wStrb <= s; awValid <= 1'b1; wValid <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    if (k == 100) begin num_errors++; tally_and_finish(); end
    `CHK(bResp, e)
  endtask
  task automatic rd(input logic [17:0] ad, input logic [1:0] e);
    int k;
    arAddr <= ad; arValid <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    if (k == 100) begin num_errors++; tally_and_finish(); end
    d = rData;
    `CHK(rResp, e)
  endtask
  task automatic opt(input logic [7:0] v);
    wr(A_OPT, {24'h00_0000, v}, 4'hf, `RCW_RESP_OKAY);
  endtask
  // waits for a timeout reset and checks how many edges it took
  task automatic waitRst(input int lo, input int hi);
    int k, r;
    r = resets;
    for (k = 0; k < hi + 50 && resets == r; k++) begin
      @(posedge clk);
      #1;
    end
    if (resets == r) begin num_errors++; tally_and_finish(); end
    `CHK(k inside {[lo:hi]}, 1'b1)
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {awValid, wValid, arValid, intRst, vecFetch, stopExec, stopMode} = '0;
    {monEnter, blankVec, brk, irqHv, rstHv} = '0;
    {awAddr, arAddr, wData, wStrb} = '0;
    rst = 1'b1; bReady = 1'b1; rReady = 1'b1; seed = 81311;
    num_errors = 0; checked = 0; resets = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(A_CLR, $random(seed), 4'hf, `RCW_RESP_OKAY);
    rd(A_OPT, `RCW_RESP_OKAY); `CHK(d[7:0], 8'h00)
    rd(A_CLR, `RCW_RESP_OKAY); `CHK(d[7:0], 8'ha5)
    a = {6'h01, 10'($random(seed)), 2'b00};
    rd(a, `RCW_RESP_SLVERR);
    wr(a, $random(seed), 4'hf, `RCW_RESP_SLVERR);
    // short rate, serviced in time with random data and strobes
    opt(8'h04);
    r0 = resets;
    repeat (3) begin
      repeat (3000 + {$random(seed)} % 1000) @(posedge clk);
      wr(A_CLR, $random(seed), {3'($random(seed)), 1'b1}, `RCW_RESP_OKAY);
    end
    `CHK(resets, r0)
    waitRst(8170, 8194);
    rd(A_CAU, `RCW_RESP_OKAY); `CHK(d[0], 1'b1)
    rd(A_OPT, `RCW_RESP_OKAY); `CHK(d[3:0], 4'h0)
    opt(8'h04);
    // pulse of 32, one hold cycle, then a full 2^13 count from zero
    waitRst(8200, 8230);
    wr(A_CAU, 32'h0000_0001, 4'hf, `RCW_RESP_OKAY);
    rd(A_CAU, `RCW_RESP_OKAY); `CHK(d[0], 1'b0)
    // stop instruction while stop is not allowed
    stopExec <= 1'b1;
    @(posedge clk);
    stopExec <= 1'b0;
    @(posedge clk);
    `CHK(illOp, 1'b1)
    rd(A_CAU, `RCW_RESP_OKAY); `CHK(d[1], 1'b1)
    // internal reset, vector fetch, allowed stop: each clears the prescaler
    for (i = 0; i < 3; i++) begin
      if (i == 2) opt(8'h02);
      repeat (i == 2 ? 300 : 3000) @(posedge clk);
      intRst <= (i == 0);
      vecFetch <= (i == 1);
      stopExec <= (i == 2);
      @(posedge clk);
      {intRst, vecFetch, stopExec} <= 3'b000;
      rd(A_STA, `RCW_RESP_OKAY); `CHK(d[11:4], 8'h00)
    end
    // disable bit, stop mode, break with voltage, monitor with voltage
    for (i = 0; i < 4; i++) begin
      opt(i == 0 ? 8'h05 : i == 1 ? 8'h06 : 8'h04);
      stopMode <= (i == 1); brk <= (i == 2); rstHv <= (i == 2);
      irqHv <= (i == 3);
      // let the test voltage pass the synchroniser before monitor entry
      repeat (3) @(posedge clk);
      monEnter <= (i == 3);
      @(posedge clk);
      monEnter <= 1'b0;
      r0 = resets;
      repeat (8400) @(posedge clk);
      rd(A_STA, `RCW_RESP_OKAY); `CHK(d[11:0], 12'h000)
      `CHK(resets, r0)
      {stopMode, brk, rstHv, irqHv} <= 4'h0;
    end
    waitRst(8180, 8210);
    // blank-vector monitor entry lasts until power-on reset
    blankVec <= 1'b1; monEnter <= 1'b1;
    @(posedge clk);
    {blankVec, monEnter} <= 2'b00;
    opt(8'h04);
    r0 = resets;
    repeat (8400) @(posedge clk);
    rd(A_STA, `RCW_RESP_OKAY); `CHK(d[18], 1'b1)
    `CHK(resets, r0)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4200) @(posedge clk);
    // the power-on clear at 4096 keeps the counter stage at zero
    rd(A_STA, `RCW_RESP_OKAY); `CHK(d[17:12], 6'h00)
    opt(8'h04);
    wr(A_CLR, $random(seed), 4'hf, `RCW_RESP_OKAY);
    waitRst(8170, 8194);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
